/* File: core/tpr_bank.sv */
`timescale 1ns/1ps
// Summary of operation
// - Transmit peak locations one to five sit as bytes low/high of 0x180, 0x181, low of 0x182.
// - Receive peak locations one to five sit as high of 0x182, then low/high of 0x183 and 0x184.
// - Each location byte is the distance to the reflection found on that pair.
// - Transmit amplitudes one and two sit at 0x185 in bits 6:0 and 14:8.
// - The upper amplitude pairs with location bits 15:8, the lower with bits 7:0.
// - Each amplitude value tells the kind of fault or interference behind the reflection.
// - Amplitude bits 15 and 7 ignore writes and always read as zero.
module tpr_bank (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [tpr_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [tpr_pkg::DATA_W-1:0]   pwdata,
    input  wire logic [3:0]                   pstrb,
    output logic      [tpr_pkg::DATA_W-1:0]   prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic                         res_valid,
    input  wire tpr_pkg::tpr_res_t            res,
    output logic                              irq
);
    import tpr_pkg::*;

    function automatic logic [REG_W-1:0] pack_pair(
        input logic [LOC_W-1:0] hi,
        input logic [LOC_W-1:0] lo
    );
        pack_pair = {hi, lo};
    endfunction

    function automatic logic [REG_W-1:0] pack_amp(
        input tpr_amp_t hi,
        input tpr_amp_t lo
    );
        pack_amp = {1'b0, hi, 1'b0, lo};
    endfunction

    function automatic logic [DATA_W-1:0] widen(input logic [REG_W-1:0] v);
        widen = {{(DATA_W-REG_W){1'b0}}, v};
    endfunction

    tpr_acc_t          state;
    tpr_acc_t          next_state;
    logic [ST_W-1:0]   status;
    logic [ST_W-1:0]   next_status;
    logic [ST_W-1:0]   mask;
    logic [ST_W-1:0]   next_mask;
    logic [ST_W-1:0]   rd_snap;
    logic [RUNS_W-1:0] runs;
    logic              have_result;
    logic [REG_W-1:0]  mem_rdata;

    wire              access;
    wire              take;
    wire              done;
    wire [IDX_W-1:0]  idx;
    wire              aligned;
    wire [WSEL_W-1:0] mem_addr;
    wire              hit_status;
    wire [ST_W-1:0]   ev_set;
    wire [ST_W-1:0]   rd_clr;
    wire              ev_overrun;
    wire              mask_wr;
    wire [DATA_W-1:0] rd_mux;
    tpr_words_t       cap_words;

    logic hit_result;
    logic hit_mask;
    logic hit_runs;
    logic hit_info;
    logic hit_stat;
    logic unmapped;

    assign access = psel & penable;
    // take: first access cycle, data is sampled; done: the edge pready is seen
    assign take = access & (state == ACC_IDLE);
    assign done = access & (state == ACC_ANSWER);
    assign idx = paddr[ADDR_W-1:2];
    assign aligned = (paddr[1:0] == 2'b00);

    always_comb
    begin
        hit_result = 1'b0;
        hit_mask   = 1'b0;
        hit_runs   = 1'b0;
        hit_info   = 1'b0;
        hit_stat   = 1'b0;
        unmapped   = 1'b0;
        if (!aligned)
            unmapped = 1'b1;
        else if ((idx >= IDX_TX_LOC_1_2) && (idx <= IDX_TX_AMP_1_2))
            hit_result = 1'b1;
        else if (idx == IDX_IRQ_STATUS)
            hit_stat = 1'b1;
        else if (idx == IDX_IRQ_MASK)
            hit_mask = 1'b1;
        else if (idx == IDX_RUN_COUNT)
            hit_runs = 1'b1;
        else if (idx == IDX_RESULT_INFO)
            hit_info = 1'b1;
        else
            unmapped = 1'b1;
    end

    assign hit_status = hit_stat;

    // address is stable from setup, so the registered memory read is ready at take
    assign mem_addr = WSEL_W'(idx - IDX_TX_LOC_1_2);

    always_comb
    begin
        case (state)
            ACC_IDLE:
            begin
                if (access)
                    next_state = ACC_ANSWER;
                else
                    next_state = ACC_IDLE;
            end
            ACC_ANSWER:
                next_state = ACC_IDLE;
            default:
                next_state = ACC_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= ACC_IDLE;
        else
            state <= next_state;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready <= 1'b0;
        else
            pready <= take;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pslverr <= 1'b0;
        else
            pslverr <= take & unmapped;
    end

    // result bytes placed exactly as software expects them
    always_comb
    begin
        cap_words = {NUM_WORDS{RST_RESULT}};
        cap_words[W_TX_LOC_1_2] = pack_pair(res.tx_loc[1], res.tx_loc[0]);
        cap_words[W_TX_LOC_3_4] = pack_pair(res.tx_loc[3], res.tx_loc[2]);
        cap_words[W_RX1_TX5_LOC] = pack_pair(res.rx_loc[0], res.tx_loc[4]);
        cap_words[W_RX_LOC_2_3] = pack_pair(res.rx_loc[2], res.rx_loc[1]);
        cap_words[W_RX_LOC_4_5] = pack_pair(res.rx_loc[4], res.rx_loc[3]);
        // amp2 follows loc2 in the high slot, amp1 follows loc1 low
        cap_words[W_TX_AMP_1_2] = pack_amp(res.tx_amp2, res.tx_amp1);
    end

    // only the engine can load; the bus has no write path into these words
    tpr_result_mem u_mem (
        .pclk       (pclk),
        .presetn    (presetn),
        .load       (res_valid),
        .load_words (cap_words),
        .raddr      (mem_addr),
        .rdata      (mem_rdata)
    );

    assign rd_mux = hit_result ? widen(mem_rdata) :
                    hit_stat   ? {{(DATA_W-ST_W){1'b0}}, status} :
                    hit_mask   ? {{(DATA_W-ST_W){1'b0}}, mask} :
                    hit_runs   ? {{(DATA_W-RUNS_W){1'b0}}, runs} :
                    hit_info   ? {{(DATA_W-1){1'b0}}, have_result} :
                    {DATA_W{1'b0}};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= {DATA_W{1'b0}};
        else if (take && !pwrite)
            prdata <= rd_mux;
    end

    // remember which status bits software actually saw, so only those clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rd_snap <= RST_STATUS;
        else if (take)
            rd_snap <= (hit_status && !pwrite) ? status : RST_STATUS;
    end

    assign rd_clr = (done && hit_status && !pwrite) ? rd_snap : RST_STATUS;

    // a new run landing before the last done was read means results were lost
    assign ev_overrun = res_valid & status[ST_DONE] & ~rd_clr[ST_DONE];
    assign ev_set = {ev_overrun, res_valid};

    // set beats clear, so an event in the clearing cycle stays visible
    assign next_status = (status & ~rd_clr) | ev_set;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status <= RST_STATUS;
        else
            status <= next_status;
    end

    assign mask_wr = done & pwrite & hit_mask & pstrb[0];
    assign next_mask = mask_wr ? pwdata[ST_W-1:0] : mask;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mask <= RST_MASK;
        else
            mask <= next_mask;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(next_status & next_mask);
    end

    // counter wraps; software compares two reads to spot a fresh run
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            runs <= RST_RUNS;
        else if (res_valid)
            runs <= runs + RUNS_W'(1);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            have_result <= 1'b0;
        else if (res_valid)
            have_result <= 1'b1;
    end

endmodule

/* File: core/tpr_pkg.sv */
package tpr_pkg;

    localparam int unsigned NUM_WORDS = 6;
    localparam int unsigned NUM_PEAKS = 5;
    localparam int unsigned LOC_W     = 8;
    localparam int unsigned AMP_W     = 7;
    localparam int unsigned REG_W     = 16;
    localparam int unsigned ADDR_W    = 12;
    localparam int unsigned DATA_W    = 32;
    localparam int unsigned IDX_W     = 10;
    localparam int unsigned WSEL_W    = 3;
    localparam int unsigned ST_W      = 2;
    localparam int unsigned RUNS_W    = 16;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_TX_LOC_1_2   = 10'h180;
    localparam logic [IDX_W-1:0] IDX_TX_LOC_3_4   = 10'h181;
    localparam logic [IDX_W-1:0] IDX_RX1_TX5_LOC  = 10'h182;
    localparam logic [IDX_W-1:0] IDX_RX_LOC_2_3   = 10'h183;
    localparam logic [IDX_W-1:0] IDX_RX_LOC_4_5   = 10'h184;
    localparam logic [IDX_W-1:0] IDX_TX_AMP_1_2   = 10'h185;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS   = 10'h190;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK     = 10'h191;
    localparam logic [IDX_W-1:0] IDX_RUN_COUNT    = 10'h192;
    localparam logic [IDX_W-1:0] IDX_RESULT_INFO  = 10'h193;

    // word slots inside the result memory
    localparam logic [WSEL_W-1:0] W_TX_LOC_1_2  = 3'h0;
    localparam logic [WSEL_W-1:0] W_TX_LOC_3_4  = 3'h1;
    localparam logic [WSEL_W-1:0] W_RX1_TX5_LOC = 3'h2;
    localparam logic [WSEL_W-1:0] W_RX_LOC_2_3  = 3'h3;
    localparam logic [WSEL_W-1:0] W_RX_LOC_4_5  = 3'h4;
    localparam logic [WSEL_W-1:0] W_TX_AMP_1_2  = 3'h5;

    localparam int unsigned HI_LSB = 8;
    localparam int unsigned LO_LSB = 0;

    localparam int unsigned ST_DONE    = 0;
    localparam int unsigned ST_OVERRUN = 1;

    localparam logic [REG_W-1:0]  RST_RESULT = 16'h0000;
    localparam logic [ST_W-1:0]   RST_STATUS = 2'h0;
    localparam logic [ST_W-1:0]   RST_MASK   = 2'h0;
    localparam logic [RUNS_W-1:0] RST_RUNS   = 16'h0000;

    typedef logic [LOC_W-1:0] tpr_loc_t;
    typedef logic [AMP_W-1:0] tpr_amp_t;

    // one finished diagnostic run, as the reflectometry engine hands it over
    typedef struct packed {
        tpr_loc_t [NUM_PEAKS-1:0] tx_loc;
        tpr_loc_t [NUM_PEAKS-1:0] rx_loc;
        tpr_amp_t                 tx_amp2;
        tpr_amp_t                 tx_amp1;
    } tpr_res_t;

    typedef logic [NUM_WORDS-1:0][REG_W-1:0] tpr_words_t;

    typedef enum logic [1:0] {
        ACC_IDLE   = 2'b00,
        ACC_ANSWER = 2'b01
    } tpr_acc_t;

endpackage

/* File: core/tpr_result_mem.sv */
`timescale 1ns/1ps
module tpr_result_mem (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         load,
    input  wire tpr_pkg::tpr_words_t          load_words,
    input  wire logic [tpr_pkg::WSEL_W-1:0]   raddr,
    output logic      [tpr_pkg::REG_W-1:0]    rdata
);
    import tpr_pkg::*;

    tpr_words_t words;
    logic [REG_W-1:0] rd_word;

    // all six words replaced in one edge so a run is never seen half written
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            words <= {NUM_WORDS{RST_RESULT}};
        else if (load)
            words <= load_words;
    end

    assign rd_word = (raddr < WSEL_W'(NUM_WORDS)) ? words[raddr] : RST_RESULT;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rdata <= RST_RESULT;
        else
            rdata <= rd_word;
    end

endmodule

/* File: tb/tpr_bank_monitor.sv */
`timescale 1ns/1ps
module tpr_bank_monitor (
    input wire logic                          pclk,
    input wire logic                          presetn,
    input wire logic                          psel,
    input wire logic                          penable,
    input wire logic                          pwrite,
    input wire logic [tpr_pkg::ADDR_W-1:0]    paddr,
    input wire logic [tpr_pkg::DATA_W-1:0]    pwdata,
    input wire logic [3:0]                    pstrb,
    input wire logic [tpr_pkg::DATA_W-1:0]    prdata,
    input wire logic                          pready,
    input wire logic                          pslverr,
    input wire logic                          res_valid,
    input wire tpr_pkg::tpr_res_t             res,
    input wire logic                          irq
);
    import tpr_pkg::*;

    tpr_res_t shadow;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            shadow <= '0;
        else if (res_valid)
            shadow <= res;
    end

    function automatic logic [REG_W-1:0] word_of(tpr_res_t r, logic [ADDR_W-1:0] a);
        case (a)
            12'h600: word_of = {r.tx_loc[1], r.tx_loc[0]};
            12'h604: word_of = {r.tx_loc[3], r.tx_loc[2]};
            12'h608: word_of = {r.rx_loc[0], r.tx_loc[4]};
            12'h60c: word_of = {r.rx_loc[2], r.rx_loc[1]};
            12'h610: word_of = {r.rx_loc[4], r.rx_loc[3]};
            default: word_of = {1'b0, r.tx_amp2, 1'b0, r.tx_amp1};
        endcase
    endfunction

    sequence rd_done(logic [ADDR_W-1:0] a);
        psel && penable && !pwrite && !pready && paddr == a ##1 pready;
    endsequence

    // read data passes the memory's output register at the end of setup,
    // so a run landing on that edge or later is not yet visible to this read
    property word_ok(logic [ADDR_W-1:0] a);
        rd_done(a) |-> prdata[REG_W-1:0] == word_of($past(shadow, 2), a);
    endproperty

    tx_loc12_a: assert property (word_ok(12'h600))
        else $error("tx peak 1-2 word wrong");
    tx_loc34_a: assert property (word_ok(12'h604))
        else $error("tx peak 3-4 word wrong");
    shared_loc_a: assert property (word_ok(12'h608))
        else $error("rx1 tx5 word wrong");
    rx_loc23_a: assert property (word_ok(12'h60c))
        else $error("rx peak 2-3 word wrong");
    rx_loc45_a: assert property (word_ok(12'h610))
        else $error("rx peak 4-5 word wrong");
    amp_word_a: assert property (word_ok(12'h614))
        else $error("amplitude word wrong");
    amp_rsvd_a: assert property (rd_done(12'h614) |-> !prdata[15] && !prdata[7])
        else $error("amplitude reserved bit set");
    ready_after_take_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready not one cycle after take");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_data_a: assert property (pslverr |-> pready && (pwrite || prdata == '0))
        else $error("error answer malformed");
endmodule

bind tpr_bank tpr_bank_monitor i_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .res_valid(res_valid), .res(res), .irq(irq)
);

/* File: tb/tpr_bank_tb_top.sv */
`timescale 1ns/1ps
`define CHK(n, x, g) begin checked++; if ((g) !== (x)) begin failures++; \
    $display("ERROR %s expected %h seen %h", n, x, g); end end
module tpr_bank_tb_top;
    import tpr_pkg::*;
    typedef struct packed { logic [11:0] a; logic [15:0] d; logic err; } tpr_row_t;
    logic                pclk;
    logic                presetn;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [ADDR_W-1:0]   paddr;
    logic [DATA_W-1:0]   pwdata;
    logic [DATA_W-1:0]   prdata;
    logic                pready;
    logic                pslverr;
    logic                res_valid;
    tpr_res_t            res;
    logic                irq;
    int                  failures;
    int                  checked;
    logic [DATA_W-1:0]   q;
    logic                e;
    tpr_res_t            r1;
    tpr_row_t            rows [7] = '{'{12'h600, 16'ha1a0, 1'b0}, '{12'h604, 16'ha3a2, 1'b0},
        '{12'h608, 16'hc0a4, 1'b0}, '{12'h60c, 16'hc2c1, 1'b0}, '{12'h610, 16'hc4c3, 1'b0},
        '{12'h614, 16'h557f, 1'b0}, '{12'h700, 16'h0000, 1'b1}};

    tpr_bank i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .res_valid(res_valid), .res(res), .irq(irq)
    );

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic stop_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // one transfer; the wait is bounded so a silent slave ends the run
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            failures++;
            stop_test();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    initial
    begin
        failures = 0;
        checked = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, res_valid} = 4'h0;
        paddr = '0;
        pwdata = '0;
        res = '0;
        for (int i = 0; i < 5; i++)
        begin
            r1.tx_loc[i] = 8'ha0 + 8'(i);
            r1.rx_loc[i] = 8'hc0 + 8'(i);
        end
        r1.tx_amp1 = 7'h7f;
        r1.tx_amp2 = 7'h55;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, 12'h644, 32'h1);
        res <= r1;
        res_valid <= 1'b1;
        @(posedge pclk);
        res_valid <= 1'b0;
        @(posedge pclk);
        `CHK("irq raised", 1'b1, irq)
        apb(1'b1, 12'h614, 32'hffffffff);
        foreach (rows[k])
        begin
            apb(1'b0, rows[k].a, 32'h0);
            `CHK("word", {16'h0, rows[k].d}, q)
            `CHK("error", rows[k].err, e)
        end
        apb(1'b0, 12'h640, 32'h0);
        `CHK("status", 32'h1, q)
        `CHK("irq cleared", 1'b0, irq)
        apb(1'b1, 12'h644, 32'h0);
        res <= r1;
        res_valid <= 1'b1;
        @(posedge pclk);
        res <= ~r1;
        @(posedge pclk);
        res_valid <= 1'b0;
        @(posedge pclk);
        `CHK("irq masked", 1'b0, irq)
        apb(1'b0, 12'h600, 32'h0);
        `CHK("second run", 32'h5e5f, q)
        apb(1'b0, 12'h614, 32'h0);
        `CHK("second amp", 32'h2a00, q)
        apb(1'b0, 12'h640, 32'h0);
        `CHK("overrun", 32'h3, q)
        apb(1'b0, 12'h648, 32'h0);
        `CHK("runs", 32'h3, q)
        apb(1'b0, 12'h640, 32'h0);
        `CHK("status cleared", 32'h0, q)
        apb(1'b0, 12'h64c, 32'h0);
        `CHK("info", 32'h1, q)
        apb(1'b0, 12'h602, 32'h0);
        `CHK("misaligned", 1'b1, e)
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK("irq reset", 1'b0, irq)
        apb(1'b0, 12'h608, 32'h0);
        `CHK("reset word", 32'h0, q)
        apb(1'b0, 12'h648, 32'h0);
        `CHK("reset runs", 32'h0, q)
        apb(1'b0, 12'h640, 32'h0);
        `CHK("reset status", 32'h0, q)
        apb(1'b0, 12'h64c, 32'h0);
        `CHK("reset info", 32'h0, q)
        stop_test();
    end
endmodule
